// ===== common/dmlcd_regs.svh
/*
 Register constants of the dot-matrix display controller: index codes,
 field positions, reset values, address wrap points and scan timing.
 Assumes it is included by bare name from design files only.
*/
`ifndef DMLCD_REGS_SVH
`define DMLCD_REGS_SVH

// ==========================================================
// Index codes (low four index bits)
`define DM_IDX_CONTROL_ONE 4'h0
`define DM_IDX_CONTROL_TWO 4'h1
`define DM_IDX_ADDRESS     4'h2
`define DM_IDX_FRAME_RATE  4'h3
`define DM_IDX_PIXEL_DATA  4'h4
`define DM_IDX_SCROLL      4'h5
`define DM_IDX_FLASH_MASK  4'h6
`define DM_IDX_FLASH_FIRST 4'h8
`define DM_IDX_FLASH_LAST  4'h9
`define DM_IDX_CONTRAST    4'ha

// ==========================================================
// Reset value of every resettable register
`define DM_REG_RESET 8'h00

// ==========================================================
// Field positions
`define DM_C1_STANDBY  0
`define DM_C1_STEP_UP  1
`define DM_C1_GRAPHIC  2
`define DM_C1_DUTY_LO  3
`define DM_C1_DUTY_HI  4
`define DM_C2_DISP_ON  0
`define DM_C2_PWR_SAVE 1
`define DM_C2_OPAMP    2
`define DM_C2_RMW      3
`define DM_C2_INC_X    4
`define DM_C2_FLASH_EN 5

// ==========================================================
// Address wrap points
`define DM_X_MAX_FULL 3'h7
`define DM_X_MAX_G16  3'h6
`define DM_X_MAX_G32  3'h4
`define DM_Y_MAX_D32  5'h1f
`define DM_Y_MAX_D16  5'h0f
`define DM_Y_MAX_D8   5'h07

// ==========================================================
// Scan timing
`define DM_BLINK_FRAMES 5'h1f
`define DM_CHAR_DOTS    5

`endif

// ===== common/dmlcd_pkg.sv
/*
 Types shared by the dot-matrix display controller.
 Assumes nothing of its surroundings.
*/
package dmlcd_pkg;
   // Scan duty as chosen in control one
   typedef enum {dmlcd_duty32, dmlcd_duty16, dmlcd_duty8} dmlcd_duty_t;
   typedef logic [7:0] dmlcd_byte_t;
endpackage

// ===== design/dmlcd_register_set.sv
/*
 Register set, display memory and scanner of the dot-matrix display
 controller, reached over strobe, select, read/write and data pins.
 Assumes all pins are asynchronous to clk; subclock is a slow input
 sampled on clk; host keeps select and read/write still at strobe fall.
*/
// Operation
// - Eight-bit write-only index picks control register
// - Select low addresses the index register only
// - Reset clears index and listed registers
// - Control one: standby, step-up, mode, duty
// - Control two: display, save, opamp, RMW, increment
// - Address register holds horizontal and vertical fields
// - Data write goes straight into memory
// - Data read latches memory byte then drives it
// - Memory, data port, scroll line not reset
// - Each mask bit makes its area blink
// - Blinking only while flash enable is set
// - First and last lines bound blinking vertically
// - Scroll line picks first displayed memory line
// - Eight-bit register sets frame rate
// - Register selects contrast resistance value
// - Duties one eighth, sixteenth, thirty-second
// - 2048-bit memory, all 2048 bits shown in graphic mode at thirty-second duty
// - Standby keeps memory, stops step-up circuit
// - Scanning paced by the subclock
// - Access happens at strobe fall per select, direction
// - Low index nibble encodes target register
// - Index kept until rewritten; only data readable
// - Data write, or read outside RMW, auto-increments address per select bit
`timescale 1ns/10ps
`default_nettype none
`include "dmlcd_regs.svh"

module dmlcd_register_set (
   input wire logic clk, // 40 MHz clock
   input wire logic rst, // Asynchronous reset, active high
   input wire logic subclock, // Slow display pacing clock, sampled
   input wire logic register_select, // Low index, high control register
   input wire logic read_write, // Low write, high read
   input wire logic access_strobe, // Access at falling edge
   input wire dmlcd_pkg::dmlcd_byte_t host_data_in, // Data lines, input side
   output dmlcd_pkg::dmlcd_byte_t host_data_out, // Data lines, output side
   output logic host_data_oe_n, // Low while data lines are driven
   output logic [31:0] common_drive_outputs, // Common select per line
   output logic [63:0] segment_drive_outputs, // Segment dots of current line
   output logic step_up_enable, // Step-up circuit running
   output logic opamp_enable, // Op-amp circuit on
   output logic power_save, // Power-save mode
   output dmlcd_pkg::dmlcd_byte_t contrast_out // Contrast resistance select
);
   import dmlcd_pkg::*;

   // ==========================================================
   // Pin synchronisers
   logic rs_m, rs_s, rw_m, rw_s, access_strobe_m, access_strobe_s, access_strobe_d, sub_m, sub_s, sub_d;
   dmlcd_byte_t data_m, data_s;

   // Every pin passes two flops; a third flop only for edge detection
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rs_m <= 1'b0;
         rs_s <= 1'b0;
         rw_m <= 1'b0;
         rw_s <= 1'b0;
         access_strobe_m <= 1'b1;
         access_strobe_s <= 1'b1;
         access_strobe_d <= 1'b1;
         sub_m <= 1'b0;
         sub_s <= 1'b0;
         sub_d <= 1'b0;
         data_m <= `DM_REG_RESET;
         data_s <= `DM_REG_RESET;
      end else begin
         rs_m <= register_select;
         rs_s <= rs_m;
         rw_m <= read_write;
         rw_s <= rw_m;
         access_strobe_m <= access_strobe;
         access_strobe_s <= access_strobe_m;
         access_strobe_d <= access_strobe_s;
         sub_m <= subclock;
         sub_s <= sub_m;
         sub_d <= sub_s;
         data_m <= host_data_in;
         data_s <= data_m;
      end
   end

   wire strobe_fall = access_strobe_d & ~access_strobe_s;
   wire strobe_rise = ~access_strobe_d & access_strobe_s;
   wire sub_tick = ~sub_d & sub_s;

   // ==========================================================
   // Registers
   dmlcd_byte_t register_index, control_one, control_two, memory_address;
   dmlcd_byte_t frame_rate_select, flash_area_mask, flash_first_line;
   dmlcd_byte_t flash_last_line, contrast_level;
   dmlcd_byte_t pixel_data_port, scroll_first_line;
   dmlcd_byte_t display_mem [256];

   // Duty decode: 00 thirty-second, 01 sixteenth, 1x eighth
   function automatic dmlcd_duty_t duty_of(input logic [1:0] bits);
      dmlcd_duty_t d;
      d = dmlcd_duty8;
      if (bits == 2'h0) begin
         d = dmlcd_duty32;
      end else if (bits == 2'h1) begin
         d = dmlcd_duty16;
      end
      return d;
   endfunction

   // Last vertical address of a duty
   function automatic logic [4:0] y_max_of(input dmlcd_duty_t d);
      logic [4:0] m;
      m = `DM_Y_MAX_D8;
      if (d == dmlcd_duty32) begin
         m = `DM_Y_MAX_D32;
      end else if (d == dmlcd_duty16) begin
         m = `DM_Y_MAX_D16;
      end
      return m;
   endfunction

   // Next address after a data access; graphic rows are narrower at thirty-second and sixteenth duty
   function automatic dmlcd_byte_t next_addr(input dmlcd_byte_t a, input dmlcd_duty_t d,
                                             input logic gfx, input logic inc_x);
      logic [2:0] x, xm;
      logic [4:0] y, ym;
      logic xw, yw;
      x = a[7:5];
      y = a[4:0];
      ym = y_max_of(d);
      xm = `DM_X_MAX_FULL;
      if (gfx && d == dmlcd_duty32) begin
         xm = `DM_X_MAX_G32;
      end else if (gfx && d == dmlcd_duty16) begin
         xm = `DM_X_MAX_G16;
      end
      xw = (x >= xm);
      yw = (y >= ym);
      if (inc_x) begin
         x = xw ? 3'h0 : 3'(x + 3'h1);
         if (xw) begin
            y = yw ? 5'h00 : 5'(y + 5'h01);
         end
      end else begin
         y = yw ? 5'h00 : 5'(y + 5'h01);
         if (yw) begin
            x = xw ? 3'h0 : 3'(x + 3'h1);
         end
      end
      return {x, y};
   endfunction

   // Access decode at strobe fall
   wire [3:0] idx = register_index[3:0];
   wire idx_mapped = (register_index[7:4] == 4'h0) &&
                     (idx <= `DM_IDX_CONTRAST) && (idx != 4'h7);
   wire index_wr = strobe_fall & ~rs_s & ~rw_s;
   wire ctrl_wr = strobe_fall & rs_s & ~rw_s & idx_mapped;
   wire data_sel = (register_index == {4'h0, `DM_IDX_PIXEL_DATA});
   wire data_wr = ctrl_wr & data_sel;
   wire data_rd = strobe_fall & rs_s & rw_s & data_sel;
   wire rmw_mode = control_two[`DM_C2_RMW];
   wire addr_step = data_wr | (data_rd & ~rmw_mode);
   // Duty is a two-state enum, so it is a variable rather than a net
   dmlcd_duty_t duty;
   assign duty = duty_of(control_one[`DM_C1_DUTY_HI:`DM_C1_DUTY_LO]);
   wire graphic_mode_select = control_one[`DM_C1_GRAPHIC];
   wire standby = control_one[`DM_C1_STANDBY];
   wire flash_enable = control_two[`DM_C2_FLASH_EN];
   wire dmlcd_byte_t mem_at_addr = display_mem[memory_address];
   wire dmlcd_byte_t addr_after = next_addr(memory_address, duty, graphic_mode_select,
                                            control_two[`DM_C2_INC_X]);

   // Resettable registers; index survives control accesses
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         register_index <= `DM_REG_RESET;
         control_one <= `DM_REG_RESET;
         control_two <= `DM_REG_RESET;
         memory_address <= `DM_REG_RESET;
         frame_rate_select <= `DM_REG_RESET;
         flash_area_mask <= `DM_REG_RESET;
         flash_first_line <= `DM_REG_RESET;
         flash_last_line <= `DM_REG_RESET;
         contrast_level <= `DM_REG_RESET;
      end else begin
         if (index_wr) begin
            register_index <= data_s;
         end
         if (ctrl_wr && idx == `DM_IDX_CONTROL_ONE) begin
            control_one <= data_s;
         end
         if (ctrl_wr && idx == `DM_IDX_CONTROL_TWO) begin
            control_two <= data_s;
         end
         if (ctrl_wr && idx == `DM_IDX_ADDRESS) begin
            memory_address <= data_s;
         end else if (addr_step) begin
            memory_address <= addr_after;
         end
         if (ctrl_wr && idx == `DM_IDX_FRAME_RATE) begin
            frame_rate_select <= data_s;
         end
         if (ctrl_wr && idx == `DM_IDX_FLASH_MASK) begin
            flash_area_mask <= data_s;
         end
         if (ctrl_wr && idx == `DM_IDX_FLASH_FIRST) begin
            flash_first_line <= data_s;
         end
         if (ctrl_wr && idx == `DM_IDX_FLASH_LAST) begin
            flash_last_line <= data_s;
         end
         if (ctrl_wr && idx == `DM_IDX_CONTRAST) begin
            contrast_level <= data_s;
         end
      end
   end

   // Memory, data port and scroll line carry no reset (kept in standby)
   always_ff @(posedge clk) begin
      if (data_wr) begin
         display_mem[memory_address] <= data_s;
      end
      if (data_rd) begin
         pixel_data_port <= mem_at_addr;
      end
      if (ctrl_wr && idx == `DM_IDX_SCROLL) begin
         scroll_first_line <= data_s;
      end
   end

   // ==========================================================
   // Data line driver
   logic read_pend;

   // Drive at strobe rise after a read; release as soon as direction is write
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         read_pend <= 1'b0;
         host_data_out <= `DM_REG_RESET;
         host_data_oe_n <= 1'b1;
      end else begin
         if (!rw_s) begin
            read_pend <= 1'b0;
            host_data_oe_n <= 1'b1;
         end else if (data_rd) begin
            read_pend <= 1'b1;
         end else if (strobe_rise && read_pend) begin
            read_pend <= 1'b0;
            host_data_out <= pixel_data_port;
            host_data_oe_n <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Scanner on subclock ticks
   dmlcd_byte_t line_div;
   logic [4:0] scan_line, frame_cnt;
   logic blink_phase;
   wire [4:0] y_max = y_max_of(duty);
   wire scan_run = ~standby & control_two[`DM_C2_DISP_ON];
   wire line_step = sub_tick & scan_run & (line_div >= frame_rate_select);
   wire frame_end = line_step & (scan_line >= y_max);

   // Line period is frame_rate_select+1 subclock ticks
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         line_div <= `DM_REG_RESET;
         scan_line <= 5'h00;
         frame_cnt <= 5'h00;
         blink_phase <= 1'b0;
      end else begin
         if (line_step) begin
            line_div <= `DM_REG_RESET;
         end else if (sub_tick && scan_run) begin
            line_div <= 8'(line_div + 8'h01);
         end
         if (frame_end) begin
            scan_line <= 5'h00;
         end else if (line_step) begin
            scan_line <= 5'(scan_line + 5'h01);
         end
         if (frame_end && frame_cnt >= `DM_BLINK_FRAMES) begin
            frame_cnt <= 5'h00;
            blink_phase <= ~blink_phase;
         end else if (frame_end) begin
            frame_cnt <= 5'(frame_cnt + 5'h01);
         end
      end
   end

   // Row fetch with scroll; wrap keeps the row within the duty
   wire [4:0] mem_row = 5'(scan_line + scroll_first_line[4:0]) & y_max;
   wire line_in_flash = ({3'h0, scan_line} >= flash_first_line) &&
                        ({3'h0, scan_line} <= flash_last_line);
   wire blank_any = flash_enable & blink_phase & line_in_flash &
                    (flash_area_mask != 8'h00);
   logic [63:0] next_segments;
   logic [31:0] next_commons;

   // Character mode keeps the five left dots of each byte
   always_comb begin
      dmlcd_byte_t b;
      b = 8'h00;
      next_segments = 64'h0;
      for (int x = 0; x < 8; x++) begin
         b = display_mem[{3'(x), mem_row}];
         if (blank_any && flash_area_mask[7 - x]) begin
            b = 8'h00;
         end
         if (graphic_mode_select) begin
            next_segments[63 - 8 * x -: 8] = b;
         end else begin
            next_segments[63 - `DM_CHAR_DOTS * x -: `DM_CHAR_DOTS] = b[7:3];
         end
      end
      next_commons = 32'h1 << scan_line;
      if (!scan_run || control_two[`DM_C2_PWR_SAVE]) begin
         next_segments = 64'h0;
         next_commons = 32'h0;
      end
   end

   // Drive outputs registered
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         common_drive_outputs <= 32'h0;
         segment_drive_outputs <= 64'h0;
         step_up_enable <= 1'b0;
         opamp_enable <= 1'b0;
         power_save <= 1'b0;
         contrast_out <= `DM_REG_RESET;
      end else begin
         common_drive_outputs <= next_commons;
         segment_drive_outputs <= next_segments;
         step_up_enable <= control_one[`DM_C1_STEP_UP] & ~standby;
         opamp_enable <= control_two[`DM_C2_OPAMP];
         power_save <= control_two[`DM_C2_PWR_SAVE];
         contrast_out <= contrast_level;
      end
   end

   // ==========================================================
   // Assertions
   property p_index_write;
      @(posedge clk) disable iff (rst)
      index_wr |=> register_index == $past(data_s);
   endproperty
   a_index_write: assert property (p_index_write) else $error("index not loaded");

   property p_select_low;
      @(posedge clk) disable iff (rst)
      (strobe_fall && !rs_s) |=> $stable(control_one) && $stable(memory_address);
   endproperty
   a_select_low: assert property (p_select_low) else $error("control hit by index access");

   property p_unmapped;
      @(posedge clk) disable iff (rst)
      (strobe_fall && rs_s && !rw_s && !idx_mapped) |=>
         $stable(control_one) && $stable(control_two) && $stable(memory_address) &&
         $stable(contrast_level) && $stable(flash_area_mask);
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped write changed state");

   property p_data_write;
      @(posedge clk) disable iff (rst)
      data_wr |=> display_mem[$past(memory_address)] == $past(data_s);
   endproperty
   a_data_write: assert property (p_data_write) else $error("memory not written");

   property p_data_read;
      @(posedge clk) disable iff (rst)
      data_rd |=> pixel_data_port == $past(mem_at_addr);
   endproperty
   a_data_read: assert property (p_data_read) else $error("read not latched");

   property p_drive_after_read;
      @(posedge clk) disable iff (rst)
      (strobe_rise && read_pend && rw_s) |=> !host_data_oe_n &&
         host_data_out == $past(pixel_data_port);
   endproperty
   a_drive_after_read: assert property (p_drive_after_read) else $error("no drive");

   property p_release;
      @(posedge clk) disable iff (rst)
      !rw_s |=> host_data_oe_n;
   endproperty
   a_release: assert property (p_release) else $error("drive kept on write");

   property p_y_increment;
      @(posedge clk) disable iff (rst)
      (data_wr && !control_two[`DM_C2_INC_X] && memory_address[4:0] < y_max) |=>
         memory_address[4:0] == 5'($past(memory_address[4:0]) + 5'h01) &&
         memory_address[7:5] == $past(memory_address[7:5]);
   endproperty
   a_y_increment: assert property (p_y_increment) else $error("bad increment");

   property p_no_flash;
      @(posedge clk) disable iff (rst)
      !flash_enable |-> !blank_any;
   endproperty
   a_no_flash: assert property (p_no_flash) else $error("blink without enable");

   property p_standby;
      @(posedge clk) disable iff (rst)
      standby |=> !step_up_enable && common_drive_outputs == 32'h0;
   endproperty
   a_standby: assert property (p_standby) else $error("standby not honoured");

   property p_duty_bound;
      @(posedge clk) disable iff (rst)
      (duty == dmlcd_duty8 && scan_line <= `DM_Y_MAX_D8) |=> scan_line <= `DM_Y_MAX_D8;
   endproperty
   a_duty_bound: assert property (p_duty_bound) else $error("line past duty");

   c_index: cover property (@(posedge clk) disable iff (rst) index_wr ##[1:100] data_wr);
   c_read: cover property (@(posedge clk) disable iff (rst) data_rd ##[1:100] !host_data_oe_n);
   c_blink: cover property (@(posedge clk) disable iff (rst) blank_any);
   c_frame: cover property (@(posedge clk) disable iff (rst) frame_end);
endmodule
`default_nettype wire

// ===== verif/dmlcd_host_model.sv
/*
 Host side of the display controller pins: select, direction, strobe, data.
 Assumes a 40 MHz clk and a testbench that resolves the shared data lines.
*/
`timescale 1ns/10ps
`default_nettype none

module dmlcd_host_model (
   input wire logic clk, // Bench clock
   output logic register_select, // Low index, high control register
   output logic read_write, // Low write, high read
   output logic access_strobe, // Falling edge starts an access
   output dmlcd_pkg::dmlcd_byte_t host_val, // Value the host drives
   output logic host_en, // Host drives the data lines
   input wire dmlcd_pkg::dmlcd_byte_t data_bus // Resolved data lines
);
   import dmlcd_pkg::*;

   // ==========================================================
   // Idle state
   initial begin
      register_select = 1'b0;
      read_write = 1'b0;
      access_strobe = 1'b1;
      host_val = 8'h00;
      host_en = 1'b1;
   end

   // Step a number of edges, then land just after the last one
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   // ==========================================================
   // One access; pins are synchronised inside, so each phase is long
   task automatic access(input logic rs, input logic rw, input dmlcd_byte_t wd,
                         output dmlcd_byte_t rd);
      hold(1);
      register_select = rs;
      read_write = rw;
      host_val = wd;
      host_en = !rw; // Release the lines on reads
      // Long setup lets a previous read drive-off finish first
      hold(8);
      access_strobe = 1'b0;
      hold(6);
      access_strobe = 1'b1;
      hold(6);
      rd = data_bus;
   endtask
endmodule

`default_nettype wire

// ===== verif/dmlcd_register_set_tb.sv
/*
 Self-checking bench of the display controller register set.
 Assumes the host model drives the pins and the bench resolves the data lines.
*/
`timescale 1ns/10ps
`default_nettype none

module dmlcd_register_set_tb;
   import dmlcd_pkg::*;

   logic clk = 1'b0;
   logic rst = 1'b1;
   logic subclock = 1'b0;
   logic register_select, read_write, access_strobe, host_en, host_data_oe_n;
   logic step_up_enable, opamp_enable, power_save;
   logic [31:0] common_drive_outputs;
   logic [63:0] segment_drive_outputs;
   logic lit, dark, dark1;
   logic [15:0] hi_seen;
   dmlcd_byte_t host_val, host_data_out, contrast_out, bus, v;
   dmlcd_byte_t bus_last = 8'h00;
   dmlcd_byte_t bad [4] = '{8'h07, 8'h0b, 8'h0f, 8'h1a};
   int failures = 0;
   int n_compared = 0;

   // ==========================================================
   // Clocks; subclock is slow and moved just after a clk edge
   always #12.5 clk = ~clk;
   always begin
      repeat (8) @(posedge clk);
      #2 subclock = ~subclock;
   end

   // Undriven lines show the inverse of their last level, never a stale match
   always @(posedge clk) bus_last <= bus;
   assign bus = !host_data_oe_n ? host_data_out : (host_en ? host_val : ~bus_last);

   dmlcd_host_model host (.clk(clk), .register_select(register_select),
      .read_write(read_write), .access_strobe(access_strobe), .host_val(host_val),
      .host_en(host_en), .data_bus(bus));

   dmlcd_register_set dut (.clk(clk), .rst(rst), .subclock(subclock),
      .register_select(register_select), .read_write(read_write),
      .access_strobe(access_strobe), .host_data_in(bus), .host_data_out(host_data_out),
      .host_data_oe_n(host_data_oe_n), .common_drive_outputs(common_drive_outputs),
      .segment_drive_outputs(segment_drive_outputs), .step_up_enable(step_up_enable),
      .opamp_enable(opamp_enable), .power_save(power_save), .contrast_out(contrast_out));

   // ==========================================================
   // Compare, access and closing tasks
   task automatic check(input dmlcd_byte_t seen, input dmlcd_byte_t exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic rs, input dmlcd_byte_t d);
      host.access(rs, 1'b0, d, v);
   endtask

   task automatic wreg(input dmlcd_byte_t idx, input dmlcd_byte_t d);
      wr(1'b0, idx);
      wr(1'b1, d);
   endtask

   // Data port read; the device must be driving when the value is taken
   task automatic rd(input dmlcd_byte_t exp);
      host.access(1'b1, 1'b1, 8'h00, v);
      check(v, exp);
      check({7'h0, host_data_oe_n}, 8'h00);
   endtask

   // Flags packed as drive-off, step-up, op-amp, power save
   function automatic dmlcd_byte_t flags();
      return {4'h0, host_data_oe_n, step_up_enable, opamp_enable, power_save};
   endfunction

   // Column 0 watched on lines 0 and 1; sampled after the edge so outputs are settled
   task automatic watch(input int n, input dmlcd_byte_t b);
      lit = 1'b0;
      dark = 1'b0;
      dark1 = 1'b0;
      repeat (n) begin
         @(posedge clk);
         #2;
         if (common_drive_outputs[0]) begin
            lit |= (segment_drive_outputs[63:56] === b);
            dark |= (segment_drive_outputs[63:56] === 8'h00);
         end
         if (common_drive_outputs[1]) begin
            dark1 |= (segment_drive_outputs[63:56] === 8'h00);
         end
      end
   endtask

   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Tests take about 12000 cycles; the limit leaves plenty of slack
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      $display("[ERR] %0t watchdog expired", $time);
      report_and_stop();
   end

   // ==========================================================
   // Test sequence
   initial begin
      repeat (6) @(posedge clk);
      #2 rst = 1'b0;
      check(flags(), 8'h08);
      check(contrast_out, 8'h00);
      check(8'(common_drive_outputs != 0), 8'h00);
      $display("test reset done");

      wreg(8'h0a, 8'h5c);
      check(contrast_out, 8'h5c);
      wr(1'b1, 8'h33);
      check(contrast_out, 8'h33);
      // Select low must reach the index only, never the contrast value
      wr(1'b0, 8'h0a);
      check(contrast_out, 8'h33);
      foreach (bad[i]) begin
         wreg(bad[i], 8'hff);
      end
      check(contrast_out, 8'h33);
      check(flags(), 8'h08);
      $display("test index done");

      wreg(8'h01, 8'h06);
      check(flags(), 8'h0b);
      wreg(8'h00, 8'h02);
      check(flags(), 8'h0f);
      wr(1'b1, 8'h03);
      check(flags(), 8'h0b);
      wreg(8'h00, 8'h00);
      wreg(8'h01, 8'h00);
      host.access(1'b1, 1'b1, 8'h00, v);
      check({7'h0, host_data_oe_n}, 8'h01);
      $display("test control done");

      // Address is still at its reset value, so writes start at zero
      wr(1'b0, 8'h04);
      for (int i = 0; i < 4; i++) begin
         wr(1'b1, 8'ha0 + 8'(i));
      end
      wreg(8'h02, 8'h00);
      wr(1'b0, 8'h04);
      for (int i = 0; i < 4; i++) begin
         rd(8'ha0 + 8'(i));
      end
      // Last line wraps to line zero of the next byte column
      wreg(8'h02, 8'h1f);
      wreg(8'h04, 8'h5a);
      wr(1'b1, 8'hc3);
      wreg(8'h02, 8'h20);
      wr(1'b0, 8'h04);
      rd(8'hc3);
      wreg(8'h01, 8'h10);
      wreg(8'h02, 8'h00);
      wreg(8'h04, 8'h11);
      wr(1'b1, 8'h22);
      wreg(8'h01, 8'h00);
      wreg(8'h02, 8'h20);
      wr(1'b0, 8'h04);
      rd(8'h22);
      $display("test memory done");

      wreg(8'h00, 8'h18);
      wreg(8'h03, 8'h00);
      wreg(8'h01, 8'h01);
      repeat (64) @(posedge clk);
      for (int i = 0; i < 40; i++) begin
         repeat (16) @(posedge clk);
         #2;
         check({6'h0, common_drive_outputs[31:8] != 0, $onehot(common_drive_outputs)}, 8'h01);
      end
      wreg(8'h00, 8'h00);
      hi_seen = 16'h0000;
      repeat (600) begin
         @(posedge clk);
         #2;
         hi_seen |= common_drive_outputs[31:16];
      end
      check(8'(hi_seen != 0), 8'h01);
      wreg(8'h01, 8'h00);
      repeat (8) @(posedge clk);
      #2;
      check(8'(common_drive_outputs != 0), 8'h00);
      $display("test scan done");

      // Scroll line is not reset, so it is written before the segments are watched
      wreg(8'h05, 8'h00);
      wreg(8'h02, 8'h00);
      wreg(8'h04, 8'h96);
      wr(1'b1, 8'h69);
      wreg(8'h06, 8'h80);
      wreg(8'h00, 8'h1c);
      wreg(8'h01, 8'h01);
      // Windows outlast one blink half period, so both phases pass by
      watch(4400, 8'h96);
      check({5'h0, lit, dark, dark1}, 8'h04);
      wr(1'b1, 8'h21);
      watch(4400, 8'h96);
      check({5'h0, lit, dark, dark1}, 8'h06);
      wreg(8'h05, 8'h01);
      wreg(8'h01, 8'h01);
      watch(300, 8'h69);
      check({5'h0, lit, dark, dark1}, 8'h04);
      $display("test segments done");
      report_and_stop();
   end
endmodule

`default_nettype wire
